//--- smhc_csr.sv
// module: control/status register, receive silo and transmit line scanner of the serial mux host
`default_nettype none
module smhc_csr #(
    parameter int DEPTH        = 64,
    parameter int CLEAR_CYCLES = smhc_pkg::CLEAR_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [1:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // characters and transmit buffer status from the microcontroller
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_char,
    input  wire logic [2:0]  rx_line,
    input  wire logic [7:0]  tx_buffer_empty,
    // toward the microcontroller
    output logic             maintenance_flag,
    output logic             micro_reset,
    output logic             lp_valid,
    output logic      [15:0] lp_data,
    output logic             tx_valid,
    output logic      [7:0]  tx_char,
    output logic      [2:0]  tx_line,
    // interrupt requests toward the bus
    output logic             receive_interrupt,
    output logic             transmit_interrupt
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk_depth
        $error("DEPTH must be a power of two of at least 2");
    end
    if (CLEAR_CYCLES < 2 || CLEAR_CYCLES > 32'h00ffffff) begin : g_chk_clr
        $error("CLEAR_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic        maintenance_flag_r, maintenance_flag_nxt;
    logic        scan_r, scan_nxt;
    logic        rie_r, rie_nxt;
    logic        sae_r, sae_nxt;
    logic        tie_r, tie_nxt;
    logic        sa_r, sa_nxt;
    logic        transmitter_ready_r, transmitter_ready_nxt;
    logic [2:0]  ready_line_number_r, ready_line_number_nxt;
    logic [2:0]  scan_ptr_r, scan_ptr_nxt;
    logic [7:0]  hold_r, hold_nxt;
    logic [23:0] clr_cnt_r, clr_cnt_nxt;
    logic [4:0]  alarm_cnt_r, alarm_cnt_nxt;
    logic [10:0] receive_buffer_r, receive_buffer_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [10:0] mem_r [DEPTH];
    logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic        lpv_r, lpv_nxt;
    logic [15:0] lpd_r, lpd_nxt;
    logic        txv_r, txv_nxt;
    logic [7:0]  txc_r, txc_nxt;
    logic [2:0]  txl_r, txl_nxt;
    logic [7:0]  len_r, len_nxt;

    logic clearing, wipe, empty, full, push, pop, rd_rb, wr_cs, wr_tb;
    assign clearing = (clr_cnt_r != 24'h000000);
    assign wipe     = sys_rst | clearing;
    assign empty    = (wp_r == rp_r);
    assign full     = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
    assign rd_rb    = reg_rd && (reg_addr == smhc_pkg::ADDR_RECEIVE_BUFFER);
    assign wr_cs    = reg_wr && (reg_addr == smhc_pkg::ADDR_CONTROL_STATUS);
    assign wr_tb    = reg_wr && (reg_addr == smhc_pkg::ADDR_TRANSMIT_BUFFER);
    // overflow drops the newest character: the silo has no overrun reporting
    assign push     = rx_valid && scan_r && !full && !clearing;
    assign pop      = rd_rb && rvalid_r;

    // ------------------------------------------------------------
    // control/status next state
    // ------------------------------------------------------------
    always_comb begin
        maintenance_flag_nxt     = maintenance_flag_r;
        scan_nxt      = scan_r;
        rie_nxt       = rie_r;
        sae_nxt       = sae_r;
        tie_nxt       = tie_r;
        clr_cnt_nxt   = clr_cnt_r;
        if (clearing) begin
            clr_cnt_nxt = clr_cnt_r - 24'h000001;
        end
        if (wr_cs && !clearing) begin
            maintenance_flag_nxt = reg_wdata[smhc_pkg::CS_MAINTENANCE_FLAG];
            scan_nxt  = reg_wdata[smhc_pkg::CS_SCAN];
            rie_nxt   = reg_wdata[smhc_pkg::CS_RIE];
            sae_nxt   = reg_wdata[smhc_pkg::CS_SAE];
            tie_nxt   = reg_wdata[smhc_pkg::CS_TIE];
            if (reg_wdata[smhc_pkg::CS_CLEAR]) begin
                clr_cnt_nxt = CLEAR_CYCLES[23:0];
            end
        end
        if (wipe) begin
            maintenance_flag_nxt = 1'b0;
            scan_nxt  = 1'b0;
            rie_nxt   = 1'b0;
            sae_nxt   = 1'b0;
            tie_nxt   = 1'b0;
        end
        if (sys_rst) begin
            clr_cnt_nxt = 24'h000000;
        end
    end

    // ------------------------------------------------------------
    // silo, alarm and receive buffer front
    // ------------------------------------------------------------
    always_comb begin
        wp_nxt        = wp_r;
        rp_nxt        = rp_r;
        receive_buffer_nxt      = receive_buffer_r;
        rvalid_nxt    = rvalid_r;
        sa_nxt        = sa_r;
        alarm_cnt_nxt = alarm_cnt_r;
        if (push) begin
            wp_nxt = wp_r + 1'b1;
            if (alarm_cnt_r == 5'(smhc_pkg::ALARM_ENTRIES - 1)) begin
                sa_nxt        = 1'b1;
                alarm_cnt_nxt = 5'h00;
            end else begin
                alarm_cnt_nxt = alarm_cnt_r + 5'h01;
            end
        end
        if (rd_rb) begin
            sa_nxt = 1'b0;
            rvalid_nxt = 1'b0;
        end
        // present the oldest entry once the front is free
        if ((!rvalid_r || pop) && !empty) begin
            receive_buffer_nxt   = mem_r[rp_r[AW-1:0]];
            rvalid_nxt = 1'b1;
            rp_nxt     = rp_r + 1'b1;
        end
        if (wipe || !scan_r) begin
            wp_nxt        = '0;
            rp_nxt        = '0;
            rvalid_nxt    = 1'b0;
            alarm_cnt_nxt = 5'h00;
        end
        if (wipe) begin
            sa_nxt = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // transmit scanner
    // ------------------------------------------------------------
    logic [2:0] cand;
    always_comb begin
        transmitter_ready_nxt     = transmitter_ready_r;
        ready_line_number_nxt    = ready_line_number_r;
        scan_ptr_nxt = scan_ptr_r;
        hold_nxt     = hold_r;
        len_nxt      = len_r;
        txv_nxt      = 1'b0;
        txc_nxt      = txc_r;
        txl_nxt      = txl_r;
        cand         = scan_ptr_r;
        if (reg_wr && reg_addr == smhc_pkg::ADDR_LINE_ENABLE) begin
            len_nxt = reg_wdata[7:0];
        end
        if (hold_r != 8'h00) begin
            hold_nxt = hold_r - 8'h01;
        end
        if (wr_tb && transmitter_ready_r) begin
            transmitter_ready_nxt = 1'b0;
            txv_nxt  = 1'b1;
            txc_nxt  = reg_wdata[7:0];
            txl_nxt  = ready_line_number_r;
            hold_nxt = 8'(smhc_pkg::RESCAN_CYCLES);
        end else if (!transmitter_ready_r && scan_r && hold_r == 8'h00) begin
            if (len_r[cand] && tx_buffer_empty[cand]) begin
                transmitter_ready_nxt  = 1'b1;
                ready_line_number_nxt = cand;
            end
            scan_ptr_nxt = scan_ptr_r + 3'h1;
        end
        if (wipe) begin
            transmitter_ready_nxt     = 1'b0;
            ready_line_number_nxt    = 3'h0;
            scan_ptr_nxt = 3'h0;
            hold_nxt     = 8'h00;
            len_nxt      = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // line parameters and read data
    // ------------------------------------------------------------
    always_comb begin
        lpv_nxt = 1'b0;
        lpd_nxt = lpd_r;
        if (reg_wr && reg_addr == smhc_pkg::ADDR_RECEIVE_BUFFER && !clearing) begin
            lpv_nxt = 1'b1;
            lpd_nxt = reg_wdata;
        end
        rdata_nxt = 16'h0000;
        case (reg_addr)
            smhc_pkg::ADDR_CONTROL_STATUS: begin
                rdata_nxt[smhc_pkg::CS_MAINTENANCE_FLAG]                  = maintenance_flag_r;
                rdata_nxt[smhc_pkg::CS_CLEAR]                  = clearing;
                rdata_nxt[smhc_pkg::CS_SCAN]                   = scan_r;
                rdata_nxt[smhc_pkg::CS_RIE]                    = rie_r;
                rdata_nxt[smhc_pkg::CS_RECEIVER_DONE]                  = rvalid_r;
                rdata_nxt[smhc_pkg::CS_LINE +: 3]              = ready_line_number_r;
                rdata_nxt[smhc_pkg::CS_SAE]                    = sae_r;
                rdata_nxt[smhc_pkg::CS_SA]                     = sa_r;
                rdata_nxt[smhc_pkg::CS_TIE]                    = tie_r;
                rdata_nxt[smhc_pkg::CS_TRANSMITTER_READY]                   = transmitter_ready_r;
            end
            smhc_pkg::ADDR_RECEIVE_BUFFER: begin
                // bits 14:11 stay zero: no parity, framing or overrun
                rdata_nxt[10:0]               = receive_buffer_r;
                rdata_nxt[smhc_pkg::RB_VALID] = rvalid_r;
            end
            smhc_pkg::ADDR_LINE_ENABLE: begin
                rdata_nxt[7:0] = len_r;
            end
            default: begin
                rdata_nxt = 16'h0000;
            end
        endcase
        if (!reg_rd) begin
            rdata_nxt = 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        maintenance_flag_r     <= maintenance_flag_nxt;
        scan_r      <= scan_nxt;
        rie_r       <= rie_nxt;
        sae_r       <= sae_nxt;
        tie_r       <= tie_nxt;
        clr_cnt_r   <= clr_cnt_nxt;
        wp_r        <= wp_nxt;
        rp_r        <= rp_nxt;
        receive_buffer_r      <= receive_buffer_nxt;                                                // stale bits kept
        rvalid_r    <= rvalid_nxt;
        sa_r        <= sa_nxt;
        alarm_cnt_r <= alarm_cnt_nxt;
        transmitter_ready_r      <= transmitter_ready_nxt;
        ready_line_number_r     <= ready_line_number_nxt;
        scan_ptr_r  <= scan_ptr_nxt;
        hold_r      <= hold_nxt;
        len_r       <= len_nxt;
        txv_r       <= txv_nxt;
        txc_r       <= txc_nxt;
        txl_r       <= txl_nxt;
        lpv_r       <= lpv_nxt;
        lpd_r       <= lpd_nxt;
        rdata_r     <= rdata_nxt;
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= {rx_line, rx_char};
        end
        if (sys_rst) begin
            receive_buffer_r  <= 11'h000;
            txc_r   <= 8'h00;
            txl_r   <= 3'h0;
            lpd_r   <= 16'h0000;
            rdata_r <= smhc_pkg::CS_RESET;
        end
    end

    assign reg_rdata          = rdata_r;
    assign maintenance_flag   = maintenance_flag_r;
    assign micro_reset        = clearing;
    assign lp_valid           = lpv_r;
    assign lp_data            = lpd_r;
    assign tx_valid           = txv_r;
    assign tx_char            = txc_r;
    assign tx_line            = txl_r;
    // one level per condition; it drops when serviced so only one is pending
    assign receive_interrupt  = rie_r & ((rvalid_r & ~sae_r) | (sa_r & sae_r));
    assign transmit_interrupt = tie_r & transmitter_ready_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_maintenance_flag;
        @(posedge clk) disable iff (sys_rst) wr_cs && !clearing |=> maintenance_flag == $past(reg_wdata[3]);
    endproperty
    a_maintenance_flag: assert property (p_maintenance_flag) else $error("maintenance flag not following write");
    // the clear write itself lands first, so the wiped csr shows one cycle after the rise
    property p_clear;
        @(posedge clk) disable iff (sys_rst) $rose(clearing)
            |=> clearing && !scan_r && !rie_r && !sae_r && !tie_r && !maintenance_flag_r;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not reset control bits");
    property p_noscan;
        @(posedge clk) disable iff (sys_rst) !scan_r |=> !rvalid_r;
    endproperty
    a_noscan: assert property (p_noscan) else $error("silo not held empty without scan");
    property p_rirq;
        @(posedge clk) disable iff (sys_rst) sae_r && !sa_r |-> !receive_interrupt;
    endproperty
    a_rirq: assert property (p_rirq) else $error("done interrupted under alarm enable");
    property p_tirq;
        @(posedge clk) disable iff (sys_rst) transmit_interrupt == (tie_r && transmitter_ready_r);
    endproperty
    a_tirq: assert property (p_tirq) else $error("transmit interrupt mismatch");
    property p_tload;
        @(posedge clk) disable iff (sys_rst) wr_tb && transmitter_ready_r |=> !transmitter_ready_r [*8];
    endproperty
    a_tload: assert property (p_tload) else $error("ready returned too soon");
    property p_rdpop;
        @(posedge clk) disable iff (sys_rst) rd_rb |=> !sa_r;
    endproperty
    a_rdpop: assert property (p_rdpop) else $error("alarm survived buffer read");
    property p_rdata;
        @(posedge clk) disable iff (sys_rst) reg_rd && reg_addr == 2'h1 |=> reg_rdata[14:11] == 4'h0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("error bits not zero");
    property p_lpr;
        @(posedge clk) disable iff (sys_rst) reg_wr && reg_addr == 2'h1 && !clearing |=> lp_valid;
    endproperty
    a_lpr: assert property (p_lpr) else $error("parameter write not passed on");
    property p_clrbit;
        @(posedge clk) disable iff (sys_rst) reg_rd && reg_addr == 2'h0 && clearing |=> reg_rdata[4];
    endproperty
    a_clrbit: assert property (p_clrbit) else $error("clear bit not shown while clearing");
    property p_wipe;
        @(posedge clk) disable iff (sys_rst) clearing |=> empty && !rvalid_r && !sa_r && !maintenance_flag;
    endproperty
    a_wipe: assert property (p_wipe) else $error("clear left silo or flags set");
    property p_ready_line_number;
        @(posedge clk) disable iff (sys_rst) clearing |=> ready_line_number_r == 3'h0 && !transmitter_ready_r && !transmit_interrupt;
    endproperty
    a_ready_line_number: assert property (p_ready_line_number) else $error("ready line not returned to zero");
    property p_transmitter_ready;
        @(posedge clk) disable iff (sys_rst) !transmitter_ready_r && !(scan_r && len_r[scan_ptr_r] && tx_buffer_empty[scan_ptr_r])
            |=> !transmitter_ready_r;
    endproperty
    a_transmitter_ready: assert property (p_transmitter_ready) else $error("ready set on a busy or disabled line");
    // the hold counter keeps the scanner quiet for the whole rescan gap
    property p_rescan;
        @(posedge clk) disable iff (sys_rst) !transmitter_ready_r && hold_r != 8'h00 |=> !transmitter_ready_r;
    endproperty
    a_rescan: assert property (p_rescan) else $error("ready set inside rescan gap");
    property p_alarm;
        @(posedge clk) disable iff (sys_rst) !sa_r && !push |=> !sa_r;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm set without an entry");
    property p_empty;
        @(posedge clk) disable iff (sys_rst) rd_rb && empty |=> !rvalid_r && !receive_interrupt;
    endproperty
    a_empty: assert property (p_empty) else $error("done flag survived read of empty silo");
    property p_front;
        @(posedge clk) disable iff (sys_rst) !rvalid_r && !empty && scan_r && !clearing |=> rvalid_r;
    endproperty
    a_front: assert property (p_front) else $error("waiting entry not presented");
    property p_transmit_buffer;
        @(posedge clk) disable iff (sys_rst) wr_tb && !transmitter_ready_r |=> !tx_valid;
    endproperty
    a_transmit_buffer: assert property (p_transmit_buffer) else $error("load accepted without ready");
    property p_lptag;
        @(posedge clk) disable iff (sys_rst) lp_valid |-> lp_data[2:0] == $past(reg_wdata[2:0]);
    endproperty
    a_lptag: assert property (p_lptag) else $error("parameter line number lost");
endmodule : smhc_csr
`default_nettype wire

//--- smhc_pkg.sv
// package: register map, field layout and timing constants of the serial mux host csr block
// Functional notes
// - maintenance bit is read/write, drives a flag to the microcontroller, cleared by init and clear.
// - writing clear starts 15 ms one-shot resetting csr and silo; bit reads one meanwhile.
// - master scan enable is read/write, gates transmit scanning and silo; cleared by resets.
// - receiver done interrupts only with receive enable set and alarm enable clear.
// - receiver done clears on buffer read and sets again while silo holds entries.
// - ready line number is read-only, valid with transmitter ready, returns to zero on reset.
// - after transmitter ready drops, rescan; a new line appears no sooner than 1.9 us.
// - alarm enable suppresses done interrupts; alarm interrupts with receive enable set.
// - alarm flag sets after 16 entries; cleared by resets or buffer read; recounts 16.
// - transmit interrupt enable requests an interrupt whenever transmitter ready is set.
// - transmitter ready sets on an enabled empty line; cleared by resets or buffer load.
// - receive buffer and line parameters share one address; reads buffer, writes parameters.
// - receive buffer is read-only and every read pops the silo.
// - with scan enable off the silo is held empty and buffer data is invalid.
// - resets empty the silo and clear data valid; low buffer bits keep stale value on clear, zero on init.
// - entry holds character in bits 7:0 and receiving line number in bits 10:8.
// - parity, framing and overrun bits of the receive buffer always read zero.
// - top buffer bit marks a valid character; software reads until it is zero.
// - a parameter write is passed to the microcontroller for the remote unit.
// - parameter word carries the target line number in its lowest three bits.
`default_nettype none
package smhc_pkg;
    // ------------------------------------------------------------
    // register addresses (word indexes on the plain port)
    // ------------------------------------------------------------
    localparam logic [1:0] ADDR_CONTROL_STATUS  = 2'h0;
    localparam logic [1:0] ADDR_RECEIVE_BUFFER  = 2'h1;  // write side is line_parameters
    localparam logic [1:0] ADDR_TRANSMIT_BUFFER = 2'h2;
    localparam logic [1:0] ADDR_LINE_ENABLE     = 2'h3;
    // ------------------------------------------------------------
    // control_status field positions
    // ------------------------------------------------------------
    localparam int CS_MAINTENANCE_FLAG = 3;
    localparam int CS_CLEAR = 4;
    localparam int CS_SCAN  = 5;
    localparam int CS_RIE   = 6;
    localparam int CS_RECEIVER_DONE = 7;
    localparam int CS_LINE  = 8;
    localparam int CS_SAE   = 12;
    localparam int CS_SA    = 13;
    localparam int CS_TIE   = 14;
    localparam int CS_TRANSMITTER_READY  = 15;
    // ------------------------------------------------------------
    // receive_buffer field positions
    // ------------------------------------------------------------
    localparam int RB_LINE  = 8;
    localparam int RB_VALID = 15;
    localparam int LP_LINE  = 0;
    // ------------------------------------------------------------
    // timing and counts
    // ------------------------------------------------------------
    localparam int  CLK_MHZ        = 100;
    localparam int  CLEAR_MS       = 15;
    localparam int  CLEAR_CYCLES   = CLEAR_MS * 1000 * CLK_MHZ;
    localparam int  RESCAN_NS_X10  = 19;  // 1.9 us expressed in tenths of a microsecond
    localparam int  RESCAN_CYCLES  = (RESCAN_NS_X10 * CLK_MHZ + 9) / 10;
    localparam int  ALARM_ENTRIES  = 16;
    localparam logic [15:0] CS_RESET = 16'h0000;
endpackage : smhc_pkg
`default_nettype wire

//--- smhc_micro_model.sv
// file: behavioural model of the microcontroller at the far side of the csr block
`default_nettype none
module smhc_micro_model (
    // clock
    input  wire logic       clk,
    // from the csr block
    input  wire logic       tx_valid,
    input  wire logic [2:0] tx_line,
    // toward the csr block
    output logic            rx_valid,
    output logic      [7:0] rx_char,
    output logic      [2:0] rx_line,
    output logic      [7:0] tx_buffer_empty
);
    timeunit 1ns;
    timeprecision 100ps;
    int hold;
    initial begin
        rx_valid = 1'b0;
        rx_char = 8'h00;
        rx_line = 3'h0;
        tx_buffer_empty = 8'hff;
        hold = 0;
    end
    // ------------------------------------------------------------
    // receive push: idle data is inverted so stale values never pass
    // ------------------------------------------------------------
    task automatic push(input logic [7:0] c, input logic [2:0] l);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_char <= c;
        rx_line <= l;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_char <= ~c;
        rx_line <= ~l;
    endtask : push
    // loaded line stays busy a while, then its buffer empties again
    always @(posedge clk) begin
        if (tx_valid) begin
            tx_buffer_empty[tx_line] <= 1'b0;
            hold <= 50;
        end else if (hold != 0) begin
            hold <= hold - 1;
            if (hold == 1) tx_buffer_empty <= 8'hff;
        end
    end
endmodule : smhc_micro_model
`default_nettype wire

//--- serial_mux_host_csr_silo_test.sv
// file: self-checking testbench of the serial mux host csr block
`default_nettype none
module serial_mux_host_csr_silo_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, lp_data, d;
    logic rx_valid, maintenance_flag, micro_reset, lp_valid, tx_valid, receive_interrupt, transmit_interrupt;
    logic [7:0] rx_char, tx_buffer_empty, tx_char;
    logic [2:0] rx_line, tx_line;
    logic [10:0] q[$];
    int failures = 0, n_checks = 0, n;
    always #5 clk = ~clk;
    smhc_csr #(.DEPTH(64), .CLEAR_CYCLES(20)) i_smhc_csr (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
        .rx_char(rx_char), .rx_line(rx_line), .tx_buffer_empty(tx_buffer_empty),
        .maintenance_flag(maintenance_flag), .micro_reset(micro_reset), .lp_valid(lp_valid), .lp_data(lp_data),
        .tx_valid(tx_valid), .tx_char(tx_char), .tx_line(tx_line), .receive_interrupt(receive_interrupt),
        .transmit_interrupt(transmit_interrupt));
    smhc_micro_model i_smhc_micro_model (.clk(clk), .tx_valid(tx_valid), .tx_line(tx_line),
        .rx_valid(rx_valid), .rx_char(rx_char), .rx_line(rx_line), .tx_buffer_empty(tx_buffer_empty));
    // ------------------------------------------------------------
    // bus tasks and comparison
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask : chk
    // whole-word writes only, parameters never read back
    task automatic wr(input logic [1:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic push_n(input int k);
        logic [7:0] c;
        logic [2:0] l;
        repeat (k) begin
            c = 8'($urandom);
            l = 3'($urandom);
            i_smhc_micro_model.push(c, l);
            q.push_back({l, c});
        end
        repeat (2) @(posedge clk);
        #1;
    endtask : push_n
    // empty silo: only the valid bit means anything
    task automatic pop;
        rd(2'h1, d);
        if (q.size() != 0) chk({1'b1, 4'h0, q.pop_front()}, d);
        else chk(16'h0000, {15'h0, d[15]});
    endtask : pop
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    initial begin
        #200us;
        failures++;
        end_sim();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h903d05e1));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rd(2'h0, d);
        chk(16'h0000, d);
        $display("test reset done");
        wr(2'h0, 16'h0068);
        chk(16'h0001, {15'h0, maintenance_flag});
        push_n(5);
        chk(16'h0001, {15'h0, receive_interrupt});
        for (int i = 0; i < 6; i++) pop();
        chk(16'h0000, {15'h0, receive_interrupt});
        $display("test receive done");
        push_n(2);
        wr(2'h0, 16'h0000);
        q.delete();
        pop();
        wr(2'h0, 16'h1060);
        push_n(15);
        rd(2'h0, d);
        chk(16'h10e0, d);
        chk(16'h0000, {15'h0, receive_interrupt});
        push_n(1);
        rd(2'h0, d);
        chk(16'h30e0, d);
        chk(16'h0001, {15'h0, receive_interrupt});
        pop();
        rd(2'h0, d);
        chk(16'h0000, {15'h0, d[13]});
        while (q.size() != 0) pop();
        pop();
        $display("test alarm done");
        for (int i = 0; i < 4; i++) begin
            n = $urandom;
            wr(2'h1, 16'(n));
            chk(16'h0001, {15'h0, lp_valid});
            chk(16'(n), lp_data);
        end
        $display("test parameters done");
        wr(2'h0, 16'h4020);
        wr(2'h3, 16'h0004);
        n = 0;
        while (transmit_interrupt !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        rd(2'h0, d);
        chk(16'hc220, d);
        chk(16'h0001, {15'h0, transmit_interrupt});
        wr(2'h2, 16'h005a);
        chk({5'h1, 8'h5a, 3'h2}, {tx_valid, tx_char, tx_line});
        chk(16'h0000, {15'h0, transmit_interrupt});
        wr(2'h2, 16'h00a5);
        chk(16'h0000, {15'h0, tx_valid});
        n = 0;
        while (transmit_interrupt !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk(16'h0001, {15'h0, n >= smhc_pkg::RESCAN_CYCLES - 2 && n < 1000});
        $display("test transmit done");
        wr(2'h0, 16'h4028);
        push_n(3);
        wr(2'h0, 16'h4038);
        chk(16'h0001, {15'h0, micro_reset});
        wr(2'h0, 16'h0040);
        rd(2'h0, d);
        chk(16'h0001, {15'h0, d[4]});
        n = 0;
        while (micro_reset !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        rd(2'h0, d);
        chk(16'h0000, d);
        chk(16'h0000, {15'h0, maintenance_flag});
        q.delete();
        wr(2'h0, 16'h0020);
        pop();
        $display("test clear done");
        end_sim();
    end
endmodule : serial_mux_host_csr_silo_test
`default_nettype wire
